/* File: hw/vport_rst_defs.vh */
`ifndef VPORT_RST_DEFS_VH
`define VPORT_RST_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_IDENT        12'h000
`define OFF_PERIPH_CTL   12'h004
`define OFF_PIN_FUNC     12'h008
`define OFF_GPIO_DIR     12'h00C
`define OFF_GPIO_IN      12'h010
`define OFF_GPIO_OUT     12'h014
`define OFF_GPIO_LAST    12'h02C
`define OFF_PORT_CTL     12'h100
`define OFF_CAP_A_CTL    12'h200
`define OFF_CAP_B_CTL    12'h300
`define OFF_DISP_CTL     12'h400
`define OFF_STATUS       12'h404

// ****************************************************************
// Field positions
// ****************************************************************
`define PCR_ENABLE       0
`define PORT_SOFT_RST    0
`define PORT_HALT        1
`define PORT_DISP_MODE   2
`define CH_ENABLE        0
`define CH_RESET         1
`define CH_BLOCK         2
`define CH_CFG_LO        3
`define CH_CFG_HI        7

// ****************************************************************
// Reset values
// ****************************************************************
`define PORT_CTL_RST     8'h02
`define CH_CTL_RST       8'h04
`define IDENT_VALUE      32'h0001_0203
`define AXI_OKAY         2'b00
`define AXI_SLVERR       2'b10

// ****************************************************************
// Timing
// ****************************************************************
`define CH_RST_SYNC_CYC  3

`endif

/* File: hw/video_port_reset_control.v */
// Summary of operation
// - While power-on reset is active, all data, sync and clock pins are high-impedance.
// - Bus reset is synchronous and may be held to keep the port off.
// - Bus reset flushes all FIFO pointers to empty.
// - Bus reset returns all registers to defaults, released on bus clock (aclk) edges.
// - Bus reset clears peripheral enable and sets port halt.
// - With peripheral enable low, all three module clocks are gated off.
// - Disabled or halted, every bus access is still acknowledged.
// - Disabled, only peripheral control, pin-function, GPIO and identification registers are reachable.
// - Disabled or halted, pins stay high-impedance unless assigned to GPIO.
// - Setting enable while halted ungates the module clocks.
// - Enabled and halted, all registers reachable; port control writable until unhalted.
// - Software reset bit does a bus reset except peripheral enable, pin-function and GPIO registers.
// - Software reset resets port logic and channel controls at once, with no channel input clock edges.
// - Software reset bit self-clears and sets port halt.
// - Unhalted, only software reset may be set; display mode drives clock pin.
// - Sync pins stay high-impedance after unhalt unless assigned to GPIO.
// - During channel reset no DMA events; reads acknowledged with any value.
// - Channel reset restores capture registers, flushes FIFO, clears capture enable.
// - Channel reset bit self-clears only after the reset actions complete.
// - Capture enabled starts counters and locks all but enable, reset, block.
// - No DMA events until block cleared while enabled; capture counting ignores block.
// - Display reset: no events, writes acknowledged, defaults, flush, self-clear.
`timescale 1ns/1ps
`include "vport_rst_defs.vh"

module video_port_reset_control #(
	parameter NPINS = 24,
	parameter CNT_W = 16
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire              por_n,
	input  wire              channel_input_clock_a,
	input  wire              channel_input_clock_b,
	input  wire              channel_input_clock_d,
	input  wire [11:0]       s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [11:0]       s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire [NPINS-1:0]  pin_in,
	output reg  [NPINS-1:0]  pin_out,
	output reg  [NPINS-1:0]  pin_oe_n,
	output reg               module_clk_en,
	output reg               fifo_flush,
	output reg  [1:0]        cap_fifo_flush,
	output reg               disp_fifo_flush,
	output reg  [1:0]        cap_counting,
	output reg  [1:0]        cap_dma_allow,
	output reg               disp_dma_allow
);

	// ****************************************************************
	// Pin map: [19:0] video_data_pins, [22:20] sync pins, [23] clock out
	// ****************************************************************
	localparam SYNC_LO = 20;
	localparam CLKO    = 23;

	reg [NPINS-1:0] pin_func_reg;
	reg [NPINS-1:0] gpio_dir_reg;
	reg [NPINS-1:0] gpio_out_reg;
	reg             periph_enable_reg;
	reg [7:0]       port_control_reg;
	reg [7:0]       chan_ctl_reg [0:2];
	reg             soft_rst_reg;
	reg             aw_hold_reg;
	reg             w_hold_reg;
	reg [11:0]      awaddr_reg;
	reg [31:0]      wdata_reg;
	reg [3:0]       wstrb_reg;
	reg [CNT_W-1:0] cap_cnt_reg [0:1];

	wire bus_rst   = ~aresetn;
	wire port_rst  = bus_rst | soft_rst_reg;
	wire halted    = port_control_reg[`PORT_HALT];
	wire active    = periph_enable_reg & ~halted;

	// ****************************************************************
	// Register access window
	// ****************************************************************
	function gpio_space;
		input [11:0] a;
		begin
			gpio_space = (a <= `OFF_GPIO_LAST);
		end
	endfunction

	function known_addr;
		input [11:0] a;
		begin
			known_addr = gpio_space(a) | (a == `OFF_PORT_CTL) | (a == `OFF_CAP_A_CTL)
				| (a == `OFF_CAP_B_CTL) | (a == `OFF_DISP_CTL) | (a == `OFF_STATUS);
		end
	endfunction

	// Disabled: only peripheral control, pin-function, GPIO and ident are reachable
	function reachable;
		input [11:0] a;
		begin
			reachable = known_addr(a) & (periph_enable_reg | gpio_space(a));
		end
	endfunction

	// ****************************************************************
	// Channel reset completion: needs edges of the channel input clock
	// ****************************************************************
	wire [2:0] ch_rst_req;
	wire [2:0] ch_rst_ack;
	wire [2:0] ch_clk;
	assign ch_clk = {channel_input_clock_d, channel_input_clock_b, channel_input_clock_a};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_ch
			assign ch_rst_req[gi] = chan_ctl_reg[gi][`CH_RESET];
			reg [`CH_RST_SYNC_CYC-1:0] edge_cnt_reg;
			reg [1:0]                  clk_sync_reg;
			reg                        clk_seen_reg;
			// Channel clock is sampled as an ordinary input; each rise counts while module_clk_en is high
			always @(posedge aclk)
			begin
				if (port_rst | ~ch_rst_req[gi])
				begin
					clk_sync_reg <= 2'b00;
					clk_seen_reg <= 1'b0;
					edge_cnt_reg <= {`CH_RST_SYNC_CYC{1'b0}};
				end
				else
				begin
					clk_sync_reg <= {clk_sync_reg[0], ch_clk[gi]};
					clk_seen_reg <= clk_sync_reg[1];
					if (clk_sync_reg[1] & ~clk_seen_reg & module_clk_en)
						edge_cnt_reg <= {edge_cnt_reg[`CH_RST_SYNC_CYC-2:0], 1'b1};
				end
			end
			assign ch_rst_ack[gi] = edge_cnt_reg[`CH_RST_SYNC_CYC-1];
		end
	endgenerate

	// ****************************************************************
	// Write path
	// ****************************************************************
	wire        wr_fire  = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	wire        wr_ok    = reachable(awaddr_reg);
	wire [7:0]  wbyte    = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
	integer     k;
	integer     j;

	always @(posedge aclk)
	begin
		if (bus_rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AXI_OKAY;
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			awaddr_reg    <= 12'h000;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
		end
		else
		begin
			// Writes are always answered so a DMA master never stalls
			s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known_addr(awaddr_reg) ? `AXI_OKAY : `AXI_SLVERR;
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Peripheral enable and pin registers (bus reset only)
	// ****************************************************************
	always @(posedge aclk)
	begin
		if (bus_rst)
		begin
			periph_enable_reg <= 1'b0;
			pin_func_reg      <= {NPINS{1'b0}};
			gpio_dir_reg      <= {NPINS{1'b0}};
			gpio_out_reg      <= {NPINS{1'b0}};
		end
		else if (wr_fire & wr_ok)
		begin
			case (awaddr_reg)
				`OFF_PERIPH_CTL: periph_enable_reg <= wdata_reg[`PCR_ENABLE];
				`OFF_PIN_FUNC:   pin_func_reg <= wdata_reg[NPINS-1:0];
				`OFF_GPIO_DIR:   gpio_dir_reg <= wdata_reg[NPINS-1:0];
				`OFF_GPIO_OUT:   gpio_out_reg <= wdata_reg[NPINS-1:0];
				default:         gpio_out_reg <= gpio_out_reg;
			endcase
		end
	end

	// ****************************************************************
	// Port control: software reset, halt lock
	// ****************************************************************
	always @(posedge aclk)
	begin
		if (port_rst)
		begin
			// Soft reset sets halt and clears itself here
			port_control_reg <= `PORT_CTL_RST;
			soft_rst_reg     <= 1'b0;
		end
		else if (wr_fire & wr_ok & (awaddr_reg == `OFF_PORT_CTL) & wstrb_reg[0])
		begin
			if (wbyte[`PORT_SOFT_RST])
				soft_rst_reg <= 1'b1;
			else if (halted)
				port_control_reg <= wbyte & ~8'h01;
		end
	end

	// ****************************************************************
	// Channel controls: [0],[1] capture, [2] display
	// ****************************************************************
	always @(posedge aclk)
	begin
		if (port_rst)
		begin
			for (k = 0; k < 3; k = k + 1)
				chan_ctl_reg[k] <= `CH_CTL_RST;
		end
		else
		begin
			for (k = 0; k < 3; k = k + 1)
			begin
				if (ch_rst_req[k] & ch_rst_ack[k])
					chan_ctl_reg[k] <= `CH_CTL_RST;
				else if (wr_fire & wr_ok & wstrb_reg[0] & ~ch_rst_req[k]
					& (awaddr_reg == (k == 0 ? `OFF_CAP_A_CTL :
						k == 1 ? `OFF_CAP_B_CTL : `OFF_DISP_CTL)))
				begin
					// Once enabled only enable, reset and block stay writable
					if (chan_ctl_reg[k][`CH_ENABLE])
						chan_ctl_reg[k][2:0] <= wbyte[2:0];
					else
						chan_ctl_reg[k] <= wbyte;
				end
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	reg [31:0] rd_val;
	always @*
	begin
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
			`OFF_IDENT:      rd_val = `IDENT_VALUE; // Arbitrary identification value
			`OFF_PERIPH_CTL: rd_val[0] = periph_enable_reg;
			`OFF_PIN_FUNC:   rd_val[NPINS-1:0] = pin_func_reg;
			`OFF_GPIO_DIR:   rd_val[NPINS-1:0] = gpio_dir_reg;
			`OFF_GPIO_IN:    rd_val[NPINS-1:0] = pin_in;
			`OFF_GPIO_OUT:   rd_val[NPINS-1:0] = gpio_out_reg;
			`OFF_PORT_CTL:   rd_val[7:0] = port_control_reg;
			`OFF_CAP_A_CTL:  rd_val[7:0] = chan_ctl_reg[0];
			`OFF_CAP_B_CTL:  rd_val[7:0] = chan_ctl_reg[1];
			`OFF_DISP_CTL:   rd_val[7:0] = chan_ctl_reg[2];
			`OFF_STATUS:     rd_val[3:0] = {active, module_clk_en, halted, periph_enable_reg};
			default:         rd_val = 32'h0000_0000;
		endcase
		if (~reachable(s_axi_araddr))
			rd_val = 32'h0000_0000;
	end

	always @(posedge aclk)
	begin
		if (bus_rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AXI_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			// Reads are answered in every state, including channel reset
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= known_addr(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Pins, clock gating, FIFO flush, capture control
	// ****************************************************************
	// Sync pin direction belongs to the channel logic, so they stay off here
	wire [NPINS-1:0] drv_next;
	assign drv_next = (pin_func_reg & gpio_dir_reg)
		| ({NPINS{active & chan_ctl_reg[2][`CH_ENABLE]}} & ~pin_func_reg
			& {{(NPINS-SYNC_LO){1'b0}}, {SYNC_LO{1'b1}}})
		| ({NPINS{active & port_control_reg[`PORT_DISP_MODE]}} & ~pin_func_reg
			& ({{(NPINS-1){1'b0}}, 1'b1} << CLKO));

	always @(posedge aclk)
	begin
		if (port_rst)
		begin
			pin_out         <= {NPINS{1'b0}};
			fifo_flush      <= 1'b1;
			cap_fifo_flush  <= 2'b11;
			disp_fifo_flush <= 1'b1;
			cap_counting    <= 2'b00;
			cap_dma_allow   <= 2'b00;
			disp_dma_allow  <= 1'b0;
			module_clk_en   <= bus_rst ? 1'b0 : periph_enable_reg;
			cap_cnt_reg[0]  <= {CNT_W{1'b0}};
			cap_cnt_reg[1]  <= {CNT_W{1'b0}};
		end
		else
		begin
			pin_out         <= gpio_out_reg;
			fifo_flush      <= 1'b0;
			module_clk_en   <= periph_enable_reg;
			cap_fifo_flush  <= {ch_rst_req[1], ch_rst_req[0]};
			disp_fifo_flush <= ch_rst_req[2];
			for (j = 0; j < 2; j = j + 1)
			begin
				cap_counting[j]  <= active & chan_ctl_reg[j][`CH_ENABLE] & ~ch_rst_req[j];
				cap_dma_allow[j] <= active & chan_ctl_reg[j][`CH_ENABLE]
					& ~chan_ctl_reg[j][`CH_BLOCK] & ~ch_rst_req[j];
				if (cap_counting[j] & module_clk_en)
					cap_cnt_reg[j] <= cap_cnt_reg[j] + {{(CNT_W-1){1'b0}}, 1'b1};
				else if (ch_rst_req[j])
					cap_cnt_reg[j] <= {CNT_W{1'b0}};
			end
			disp_dma_allow  <= active & chan_ctl_reg[2][`CH_ENABLE]
				& ~chan_ctl_reg[2][`CH_BLOCK] & ~ch_rst_req[2];
		end
	end

	// ****************************************************************
	// Power-on reset: pins released only after the flops take over
	// ****************************************************************
	// Asynchronous so the pins float even before the bus clock runs
	always @(posedge aclk or negedge por_n)
	begin
		if (~por_n)
			pin_oe_n <= {NPINS{1'b1}};
		else if (port_rst)
			pin_oe_n <= {NPINS{1'b1}};
		else
			pin_oe_n <= ~drv_next;
	end

endmodule // video_port_reset_control

/* File: verif/video_port_reset_control_properties.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus handshake and reset checks
// ****************************************************************
module video_port_reset_control_properties #(
	parameter NPINS = 24
) (
	input logic              aclk,
	input logic              aresetn,
	input logic              por_n,
	input logic              s_axi_awvalid,
	input logic              s_axi_wvalid,
	input logic [1:0]        s_axi_bresp,
	input logic              s_axi_bvalid,
	input logic              s_axi_bready,
	input logic              s_axi_arvalid,
	input logic [31:0]       s_axi_rdata,
	input logic              s_axi_rvalid,
	input logic              s_axi_rready,
	input logic [NPINS-1:0]  pin_oe_n,
	input logic              module_clk_en,
	input logic              fifo_flush,
	input logic [1:0]        cap_fifo_flush,
	input logic [1:0]        cap_counting,
	input logic [1:0]        cap_dma_allow,
	input logic              disp_dma_allow
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_pend;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	sequence s_wr_done;
		##[1:8] s_axi_bvalid;
	endsequence
	sequence s_rd_done;
		##[1:6] s_axi_rvalid;
	endsequence
	// Reset checks see reset itself, so only power-on masks them
	a_reset_tristate: assert property (disable iff (!por_n)
		!aresetn |=> &pin_oe_n && fifo_flush && !module_clk_en) else $error("port live in reset");
	a_reset_quiet: assert property (disable iff (!por_n)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && cap_dma_allow == 2'b00
		&& cap_counting == 2'b00) else $error("bus or channel active in reset");
	a_write_acked: assert property (s_wr_pend |-> s_wr_done)
		else $error("write not acknowledged");
	a_read_acked: assert property (s_axi_arvalid && !s_axi_rvalid |-> s_rd_done)
		else $error("read not acknowledged");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_gated_idle: assert property (!module_clk_en [*2] |-> cap_counting == 2'b00
		&& cap_dma_allow == 2'b00 && !disp_dma_allow) else $error("activity with clocks gated");
	a_flush_no_dma: assert property (fifo_flush [*2] |-> cap_dma_allow == 2'b00
		&& !disp_dma_allow) else $error("events during port flush");
	a_chan_rst_quiet: assert property (cap_fifo_flush[0] [*2] |->
		!cap_dma_allow[0] && !cap_counting[0]) else $error("events during channel reset");
endmodule // video_port_reset_control_properties

bind video_port_reset_control video_port_reset_control_properties #(.NPINS(NPINS)) u_props (
	.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_oe_n(pin_oe_n),
	.module_clk_en(module_clk_en), .fifo_flush(fifo_flush), .cap_fifo_flush(cap_fifo_flush),
	.cap_counting(cap_counting), .cap_dma_allow(cap_dma_allow), .disp_dma_allow(disp_dma_allow));

/* File: verif/vport_far_side.sv */
`timescale 1ns/1ps
// ****************************************************************
// Pads and video sources outside the port
// ****************************************************************
module vport_far_side #(
	parameter NPINS = 24
) (
	input  logic [NPINS-1:0] pin_out,
	input  logic [NPINS-1:0] pin_oe_n,
	output logic [NPINS-1:0] pin_in,
	output logic             clk_a,
	output logic             clk_b,
	output logic             clk_d
);
	logic [NPINS-1:0] ext_pat;
	initial
	begin
		clk_a = 1'b0;
		clk_b = 1'b0;
		clk_d = 1'b0;
		ext_pat = '0;
	end
	// Video sources run free and unrelated to the bus clock
	always #35 clk_a = ~clk_a;
	always #45 clk_b = ~clk_b;
	always #37 clk_d = ~clk_d;
	// Released pads read ext_pat, negated on each clk_a rise, so they stay at zero
	always @(posedge clk_a) ext_pat <= ~ext_pat + 1'b1;
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_pat);
endmodule // vport_far_side

/* File: verif/tb_video_port_reset_control.sv */
`timescale 1ns/1ps
`include "vport_rst_defs.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 200) begin @(posedge aclk); n++; end \
	if (n >= 200) timeout_hit(); end
module tb_video_port_reset_control;
	typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
	logic        aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, clk_en, flush, dflush, ddma;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rr, br, cflush, ccount, cdma;
	logic [23:0] pin_in, pin_out, pin_oe_n;
	logic        ck_a, ck_b, ck_d;
	int          errors, compares, n, i;
	// ****************************************************************
	// Ordinary accesses, in order: disabled, halted, unhalted
	// ****************************************************************
	row_t rows [11] = '{
		'{1'b0, `OFF_IDENT, 32'h0, `IDENT_VALUE, `AXI_OKAY},
		'{1'b0, `OFF_PORT_CTL, 32'h0, 32'h0, `AXI_OKAY},
		'{1'b1, `OFF_PERIPH_CTL, 32'h1, 32'h1, `AXI_OKAY},
		'{1'b0, `OFF_PORT_CTL, 32'h0, 32'h2, `AXI_OKAY},
		'{1'b1, `OFF_PORT_CTL, 32'h6, 32'h6, `AXI_OKAY},
		'{1'b1, `OFF_PORT_CTL, 32'h7, 32'h2, `AXI_OKAY},
		'{1'b1, `OFF_PORT_CTL, 32'h0, 32'h0, `AXI_OKAY},
		'{1'b1, `OFF_PORT_CTL, 32'h4, 32'h0, `AXI_OKAY},
		'{1'b1, `OFF_CAP_A_CTL, 32'hD, 32'hD, `AXI_OKAY},
		'{1'b1, `OFF_CAP_A_CTL, 32'hFD, 32'hD, `AXI_OKAY},
		'{1'b0, 12'h800, 32'h0, 32'h0, `AXI_SLVERR}};
	video_port_reset_control DUT (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.channel_input_clock_a(ck_a), .channel_input_clock_b(ck_b), .channel_input_clock_d(ck_d),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .module_clk_en(clk_en),
		.fifo_flush(flush), .cap_fifo_flush(cflush), .disp_fifo_flush(dflush),
		.cap_counting(ccount), .cap_dma_allow(cdma), .disp_dma_allow(ddma));
	vport_far_side u_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
		.clk_a(ck_a), .clk_b(ck_b), .clk_d(ck_d));
	always #10 aclk = ~aclk;
	task automatic print_verdict;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic timeout_hit;
		errors++;
		print_verdict();
	endtask
	// Each valid drops at its own handshake edge; response ready stays up until the answer
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				br = bresp;
				bready <= 1'b0;
			end
		end
		while ((awvalid || wvalid || bready) && n < 200);
		if (n >= 200)
			timeout_hit();
	endtask
	task automatic axi_rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				rd = rdata;
				rr = rresp;
				rready <= 1'b0;
			end
		end
		while ((arvalid || rready) && n < 200);
		if (n >= 200)
			timeout_hit();
	endtask
	initial
	begin
		{aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		errors = 0;
		compares = 0;
		repeat (2) @(posedge aclk);
		por_n <= 1'b1;
		aresetn <= 1'b1;
		`CHK(pin_oe_n, 24'hFF_FFFF)
		`CHK(clk_en, 1'b0)
		for (i = 0; i < 11; i++)
		begin
			if (rows[i].wr)
			begin
				axi_wr(rows[i].a, rows[i].d);
				`CHK(br, `AXI_OKAY)
			end
			axi_rd(rows[i].a);
			`CHK(rd, rows[i].e)
			`CHK(rr, rows[i].r)
		end
		// ****************************************************************
		// Capture channel: block, enable, channel reset, soft reset
		// ****************************************************************
		`CHK(clk_en, 1'b1)
		`CHK(cdma[0], 1'b0)
		axi_wr(`OFF_CAP_A_CTL, 32'h9);
		`WAIT(cdma[0] === 1'b1)
		`CHK(ccount[0], 1'b1)
		axi_wr(`OFF_CAP_A_CTL, 32'hB);
		`CHK(cflush[0], 1'b1)
		axi_rd(`OFF_CAP_A_CTL);
		`CHK(rr, `AXI_OKAY)
		`WAIT(cflush[0] === 1'b0)
		axi_rd(`OFF_CAP_A_CTL);
		`CHK(rd, 32'h4)
		axi_wr(`OFF_CAP_A_CTL, 32'h9);
		axi_wr(`OFF_PORT_CTL, 32'h1);
		axi_rd(`OFF_CAP_A_CTL);
		`CHK(rd, 32'h4)
		axi_rd(`OFF_PORT_CTL);
		`CHK(rd, 32'h2)
		`CHK(clk_en, 1'b1)
		// ****************************************************************
		// GPIO pin, display enable and display channel reset
		// ****************************************************************
		axi_wr(`OFF_PIN_FUNC, 32'h1);
		axi_wr(`OFF_GPIO_DIR, 32'h1);
		axi_wr(`OFF_GPIO_OUT, 32'h1);
		axi_wr(`OFF_PORT_CTL, 32'h0);
		axi_wr(`OFF_DISP_CTL, 32'h1);
		`CHK(pin_oe_n, 24'hF0_0000)
		`CHK(pin_out[0], 1'b1)
		`CHK(ddma, 1'b1)
		axi_rd(`OFF_GPIO_IN);
		`CHK(rd[0], 1'b1)
		axi_wr(`OFF_DISP_CTL, 32'h3);
		`CHK(dflush, 1'b1)
		`CHK(ddma, 1'b0)
		`WAIT(dflush === 1'b0)
		axi_rd(`OFF_DISP_CTL);
		`CHK(rd, 32'h4)
		// ****************************************************************
		// Bus reset in mid-run
		// ****************************************************************
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		`CHK(pin_oe_n, 24'hFF_FFFF)
		`CHK(flush, 1'b1)
		`CHK(clk_en, 1'b0)
		aresetn <= 1'b1;
		axi_rd(`OFF_PERIPH_CTL);
		`CHK(rd, 32'h0)
		print_verdict();
	end
endmodule // tb_video_port_reset_control
